// [rtl/sfr_core.sv]
// sfr_core: serial flash read and erase sequencer with its own byte array.
// assumes pins arrive asynchronously; link clock at most a quarter of clock.
`timescale 1ns/10ps
module sfr_core
    import sfr_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEFAULT,
    parameter int PAGE_CYC = PAGE_WIPE_CYC,
    parameter int FOUR_KB_CYC = FOUR_KB_WIPE_CYC,
    parameter int SMALL_CYC = BLOCK_SMALL_CYC,
    parameter int LARGE_CYC = BLOCK_LARGE_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic io_lane_zero_in,
    output logic io_lane_zero_out,
    output logic io_lane_zero_oe,
    input wire logic io_lane_one_in,
    output logic io_lane_one_out,
    output logic io_lane_one_oe,
    input wire logic [4:0] protect_level_bits,
    input wire logic dummy_len_sel,
    input wire logic load_we,
    input wire logic [ADDR_W-1:0] load_addr,
    input wire logic [7:0] load_data,
    output logic busy_flag,
    output logic write_latch
);
    localparam int SECTORS = 2 ** (ADDR_W - FOUR_KB_SH);

    logic [7:0] mem [0:(2**ADDR_W)-1];
    logic cs_m, cs_s, cs_d, sclk_m, sclk_s, sclk_d, io0_m, io0_s, io1_m, io1_s;
    logic sclk_rise, sclk_fall, cs_rise;
    sfr_state_t state;
    logic [7:0] opcode, cmd_sh, sh_out, cur_byte, fifo_data, stat_byte;
    logic [23:0] addr_sh, next_addr;
    logic [5:0] cnt, tot, dummy_len;
    logic [2:0] bleft;
    logic dual_in, dual_out, is_read_op, is_erase_op, at_bnd;
    logic fetch_on, push, pop, fifo_ready, fifo_valid;
    logic [ADDR_W-1:0] fetch_addr, wipe_addr, region_last;
    logic [WIPE_CNT_W-1:0] wipe_left;
    logic [TIMER_W-1:0] timer;
    logic erase_go, prot_hit, wipe_we;
    int reg_sh;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // protection covers bp sectors counted down from the top of the array
    function automatic logic is_prot(input logic [ADDR_W-1:0] a, input logic [4:0] bp);
        int sec;
        sec = int'(a >> FOUR_KB_SH);
        return (bp != 5'h00) && (sec >= (SECTORS - int'(bp)));
    endfunction : is_prot

    function automatic logic fast_class(input logic [7:0] op);
        return (op == OP_FAST_READ) || (op == OP_DUAL_OUT_READ) || (op == OP_DUAL_IO_READ);
    endfunction : fast_class

    // ----------------------------------------------------------------
    // pin synchronisers and edge finding
    // ----------------------------------------------------------------
    // two flops on every pin; cs and sclk add a third stage, used only for edge finding
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            io0_m <= 1'b0;
            io0_s <= 1'b0;
            io1_m <= 1'b0;
            io1_s <= 1'b0;
        end else begin
            cs_m <= cs_n_pin;
            cs_s <= cs_m;
            cs_d <= cs_s;
            sclk_m <= sclk_pin;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            io0_m <= io_lane_zero_in;
            io0_s <= io0_m;
            io1_m <= io_lane_one_in;
            io1_s <= io1_m;
        end
    end

    assign sclk_rise = sclk_s && !sclk_d && !cs_s;
    assign sclk_fall = !sclk_s && sclk_d && !cs_s;
    assign cs_rise = cs_s && !cs_d;

    // ----------------------------------------------------------------
    // decode terms
    // ----------------------------------------------------------------
    assign is_read_op = (opcode == OP_READ) || fast_class(opcode);
    assign is_erase_op = (opcode == OP_PAGE_WIPE) || (opcode == OP_FOUR_KB_WIPE)
        || (opcode == OP_BLOCK_WIPE_SMALL) || (opcode == OP_BLOCK_WIPE_LARGE);
    assign dual_out = (opcode == OP_DUAL_OUT_READ) || (opcode == OP_DUAL_IO_READ);
    assign dummy_len = (opcode == OP_FAST_READ) ? FAST_DUMMY_EDGES
        : (opcode == OP_DUAL_OUT_READ) ? DUAL_OUT_DUMMY_EDGES
        : dummy_len_sel ? DUAL_IO_DUMMY_LONG : DUAL_IO_DUMMY_SHORT;
    // upper bit of a pair arrives on lane one
    assign next_addr = dual_in ? {addr_sh[21:0], io1_s, io0_s} : {addr_sh[22:0], io0_s};
    assign stat_byte = {1'b0, protect_level_bits, write_latch, busy_flag};
    assign at_bnd = (tot == ERASE_EDGES);

    // region size by opcode; page erase, like the rest, takes no trailing dummy byte
    always_comb begin
        case (opcode)
            OP_PAGE_WIPE: reg_sh = PAGE_SH;
            OP_FOUR_KB_WIPE: reg_sh = FOUR_KB_SH;
            OP_BLOCK_WIPE_SMALL: reg_sh = BLOCK_SMALL_SH;
            default: reg_sh = BLOCK_LARGE_SH;
        endcase
    end

    assign region_last = addr_sh[ADDR_W-1:0] | ADDR_W'((32'h1 << reg_sh) - 32'h1);
    assign prot_hit = is_prot(region_last, protect_level_bits);
    // exactly ERASE_EDGES (32) rising edges, latch set, nothing running
    assign erase_go = cs_rise && is_erase_op && at_bnd && write_latch && !busy_flag;

    // ----------------------------------------------------------------
    // command, address and dummy phases
    // ----------------------------------------------------------------
    // everything is sampled on the detected rising link edge
    always_ff @(posedge clock) begin
        if (!rst_n || cs_s) begin
            state <= ST_CMD;
            opcode <= OP_NONE;
            cmd_sh <= 8'h00;
            addr_sh <= 24'h000000;
            cnt <= 6'h00;
            dual_in <= 1'b0;
        end else if (sclk_rise) begin
            cnt <= cnt + 6'h01;
            case (state)
                ST_CMD: begin
                    cmd_sh <= {cmd_sh[6:0], io0_s};
                    if (cnt == LAST_CMD_EDGE) begin
                        opcode <= {cmd_sh[6:0], io0_s};
                        cnt <= 6'h00;
                        dual_in <= ({cmd_sh[6:0], io0_s} == OP_DUAL_IO_READ);
                        if (fast_class({cmd_sh[6:0], io0_s}) && busy_flag) begin
                            state <= ST_HOLD;
                        end else if ({cmd_sh[6:0], io0_s} == OP_STATUS_READ) begin
                            state <= ST_STAT;
                        end else if (({cmd_sh[6:0], io0_s} == OP_WRITE_UNLOCK)) begin
                            state <= ST_HOLD;
                        end else begin
                            state <= ST_ADDR;
                        end
                    end
                end
                ST_ADDR: begin
                    addr_sh <= next_addr;
                    if (cnt == (dual_in ? LAST_ADDR_DUAL : LAST_ADDR_SINGLE)) begin
                        cnt <= 6'h00;
                        if (!is_read_op) begin
                            state <= ST_HOLD; // erase waits for chip select
                        end else if (opcode == OP_READ) begin
                            state <= ST_DATA;
                        end else begin
                            state <= ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (cnt == dummy_len - 6'h01) begin
                        state <= ST_DATA;
                    end
                end
                default: begin
                    cnt <= cnt;
                end
            endcase
        end
    end

    // total rising edges in this selection, saturating
    always_ff @(posedge clock) begin
        if (!rst_n || cs_s) begin
            tot <= 6'h00;
        end else if (sclk_rise && tot != EDGE_CNT_MAX) begin
            tot <= tot + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // array fetch into the fifo
    // ----------------------------------------------------------------
    // fetch starts as the last address bits land, ahead of the dummy phase
    always_ff @(posedge clock) begin
        if (!rst_n || cs_s) begin
            fetch_on <= 1'b0;
            fetch_addr <= '0;
        end else if (sclk_rise && state == ST_ADDR && is_read_op
            && cnt == (dual_in ? LAST_ADDR_DUAL : LAST_ADDR_SINGLE)) begin
            fetch_on <= 1'b1;
            fetch_addr <= next_addr[ADDR_W-1:0];
        end else if (push) begin
            fetch_addr <= fetch_addr + 1'b1; // natural wrap to zero
        end
    end

    assign push = fetch_on && fifo_ready;
    assign pop = sclk_fall && state == ST_DATA && bleft == 3'h0 && fifo_valid;

    sfr_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .flush(cs_s),
        .in_valid(fetch_on),
        .in_ready(fifo_ready),
        .in_data(mem[fetch_addr]),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // ----------------------------------------------------------------
    // output shifter
    // ----------------------------------------------------------------
    // an underrun (host far too fast) sends erased bytes, not stale ones
    assign cur_byte = (bleft != 3'h0) ? sh_out
        : (state == ST_STAT) ? stat_byte
        : fifo_valid ? fifo_data : ERASED_BYTE;

    // lanes change only on the detected falling link edge, or clear while chip select is high
    always_ff @(posedge clock) begin
        if (!rst_n || cs_s) begin
            sh_out <= 8'h00;
            bleft <= 3'h0;
            io_lane_one_out <= 1'b0;
            io_lane_zero_out <= 1'b0;
            io_lane_one_oe <= 1'b0;
            io_lane_zero_oe <= 1'b0;
        end else if (sclk_fall && (state == ST_DATA || state == ST_STAT)) begin
            io_lane_one_out <= cur_byte[7];
            io_lane_one_oe <= 1'b1;
            if (dual_out && state == ST_DATA) begin
                io_lane_zero_out <= cur_byte[6];
                io_lane_zero_oe <= 1'b1;
                sh_out <= {cur_byte[5:0], 2'b00};
                bleft <= (bleft == 3'h0) ? DUAL_LAST_PAIR : bleft - 3'h1;
            end else begin
                sh_out <= {cur_byte[6:0], 1'b0};
                bleft <= (bleft == 3'h0) ? SINGLE_LAST_BIT : bleft - 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // write latch and self-timed erase
    // ----------------------------------------------------------------
    // unlock is refused while busy, so set and clear never meet
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            write_latch <= 1'b0;
        end else if (cs_rise && opcode == OP_WRITE_UNLOCK && tot == UNLOCK_EDGES && !busy_flag) begin
            write_latch <= 1'b1;
        end else if (erase_go && prot_hit) begin
            write_latch <= 1'b0; // protected: no cycle, latch still dropped
        end else if (busy_flag && timer == '0 && wipe_left == '0) begin
            write_latch <= 1'b0;
        end
    end

    // busy spans both the timer and the byte walk over the region
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_flag <= 1'b0;
            timer <= '0;
            wipe_left <= '0;
            wipe_addr <= '0;
        end else if (erase_go && !prot_hit) begin
            busy_flag <= 1'b1;
            wipe_addr <= addr_sh[ADDR_W-1:0] & ~ADDR_W'((32'h1 << reg_sh) - 32'h1);
            wipe_left <= WIPE_CNT_W'(32'h1 << reg_sh);
            case (opcode)
                OP_PAGE_WIPE: timer <= TIMER_W'(PAGE_CYC);
                OP_FOUR_KB_WIPE: timer <= TIMER_W'(FOUR_KB_CYC);
                OP_BLOCK_WIPE_SMALL: timer <= TIMER_W'(SMALL_CYC);
                default: timer <= TIMER_W'(LARGE_CYC);
            endcase
        end else if (busy_flag) begin
            if (timer != '0) begin
                timer <= timer - 1'b1;
            end
            if (wipe_left != '0) begin
                wipe_left <= wipe_left - 1'b1;
                wipe_addr <= wipe_addr + 1'b1;
            end
            if (timer == '0 && wipe_left == '0) begin
                busy_flag <= 1'b0;
            end
        end
    end

    assign wipe_we = busy_flag && wipe_left != '0;

    // array writes: erase walk first, side load whenever the walk is not writing
    always_ff @(posedge clock) begin
        if (wipe_we) begin
            mem[wipe_addr] <= ERASED_BYTE;
        end else if (load_we) begin
            mem[load_addr] <= load_data;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_go;
        erase_go && !prot_hit;
    endsequence
    sequence s_run;
        busy_flag [*2];
    endsequence

    property p_busy_start;
        s_go |=> s_run;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("erase did not raise busy");

    property p_latch_end;
        $fell(busy_flag) |-> !write_latch;
    endproperty
    a_latch_end: assert property (p_latch_end) else $error("latch held after erase");

    property p_need_latch;
        $rose(busy_flag) |-> $past(write_latch);
    endproperty
    a_need_latch: assert property (p_need_latch) else $error("erase without latch");

    property p_boundary;
        $rose(busy_flag) |-> $past(at_bnd) && $past(cs_rise);
    endproperty
    a_boundary: assert property (p_boundary) else $error("erase off byte boundary");

    property p_reject_fast;
        sclk_rise && state == ST_CMD && cnt == LAST_CMD_EDGE && busy_flag
            && fast_class({cmd_sh[6:0], io0_s}) |=> state == ST_HOLD;
    endproperty
    a_reject_fast: assert property (p_reject_fast) else $error("fast read taken while busy");

    property p_addr_step;
        push && !cs_s |=> fetch_addr == $past(fetch_addr) + 1'b1;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("read address did not step");

    property p_fall_only;
        $changed(io_lane_one_out) && !cs_s |-> $past(sclk_fall);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("output moved off falling edge");

    property p_protect;
        $rose(busy_flag) |-> !$past(prot_hit);
    endproperty
    a_protect: assert property (p_protect) else $error("protected region erased");

    property p_prot_latch;
        erase_go && prot_hit |=> !write_latch && !busy_flag;
    endproperty
    a_prot_latch: assert property (p_prot_latch) else $error("protected erase kept latch");
endmodule : sfr_core

// [rtl/sfr_pkg.sv]
// sfr_pkg: opcodes, phase lengths, erase geometry and timing for the flash sequencer.
// assumes a 50 MHz system clock and a link clock well below a quarter of it.
package sfr_pkg;
    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] OP_PAGE_WIPE = 8'h81;
    localparam logic [7:0] OP_FOUR_KB_WIPE = 8'h20;
    localparam logic [7:0] OP_BLOCK_WIPE_SMALL = 8'h52;
    localparam logic [7:0] OP_BLOCK_WIPE_LARGE = 8'hD8;
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_NONE = 8'h00;
    // ----------------------------------------------------------------
    // phase lengths, in rising link clock edges; the output bit counts step on falling edges
    // ----------------------------------------------------------------
    localparam logic [5:0] LAST_CMD_EDGE = 6'h07;
    localparam logic [5:0] LAST_ADDR_SINGLE = 6'h17;
    localparam logic [5:0] LAST_ADDR_DUAL = 6'h0B;
    localparam logic [5:0] FAST_DUMMY_EDGES = 6'h08;
    localparam logic [5:0] DUAL_OUT_DUMMY_EDGES = 6'h08;
    localparam logic [5:0] DUAL_IO_DUMMY_SHORT = 6'h04;
    localparam logic [5:0] DUAL_IO_DUMMY_LONG = 6'h08;
    localparam logic [5:0] ERASE_EDGES = 6'h20;
    localparam logic [5:0] UNLOCK_EDGES = 6'h08;
    localparam logic [5:0] EDGE_CNT_MAX = 6'h3F;
    localparam logic [2:0] SINGLE_LAST_BIT = 3'h7;
    localparam logic [2:0] DUAL_LAST_PAIR = 3'h3;
    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W_DEFAULT = 18;
    localparam int PAGE_SH = 8;
    localparam int FOUR_KB_SH = 12;
    localparam int BLOCK_SMALL_SH = 15;
    localparam int BLOCK_LARGE_SH = 16;
    localparam int WIPE_CNT_W = 17;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int FIFO_DEPTH = 4;
    localparam int BYTE_W = 8;
    // ----------------------------------------------------------------
    // self-timed erase durations
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int PAGE_WIPE_TIME_US = 1000;
    localparam int FOUR_KB_WIPE_TIME_US = 1000;
    localparam int BLOCK_WIPE_TIME_SMALL_US = 1000;
    localparam int BLOCK_WIPE_TIME_LARGE_US = 1000;
    localparam int PAGE_WIPE_CYC = PAGE_WIPE_TIME_US * CLK_MHZ;
    localparam int FOUR_KB_WIPE_CYC = FOUR_KB_WIPE_TIME_US * CLK_MHZ;
    localparam int BLOCK_SMALL_CYC = BLOCK_WIPE_TIME_SMALL_US * CLK_MHZ;
    localparam int BLOCK_LARGE_CYC = BLOCK_WIPE_TIME_LARGE_US * CLK_MHZ;
    localparam int TIMER_W = 24;
    // ----------------------------------------------------------------
    // command phases
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_CMD = 6'h01,
        ST_ADDR = 6'h02,
        ST_DUMMY = 6'h04,
        ST_DATA = 6'h08,
        ST_STAT = 6'h10,
        ST_HOLD = 6'h20
    } sfr_state_t;
endpackage : sfr_pkg

// [rtl/sfr_fifo.sv]
// sfr_fifo: small synchronous fifo with valid/ready on both sides and a flush.
// assumes both sides on the one system clock; depth is a power of two.
`timescale 1ns/10ps
module sfr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] fill;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // handshakes
    // ----------------------------------------------------------------
    // full test at the fill width; a narrower constant would wrap to zero
    assign in_ready = (fill != (PW+1)'(DEPTH)) && !flush;
    assign out_valid = (fill != '0);
    assign out_data = store[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready && !flush;

    // storage has no reset, only the pointers and fill level do
    always_ff @(posedge clock) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level; flush empties at once
    always_ff @(posedge clock) begin
        if (!rst_n || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : sfr_fifo

// [bench/sfr_host.sv]
// sfr_host: spi host model, mode 0, msb first, single lane out.
// assumes callers wait on its task; link period is 8 clocks.
`timescale 1ns/10ps
module sfr_host (
    input wire logic clock,
    input wire logic miso,
    input wire logic miso0,
    input wire logic dual,
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    output logic lane_one
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        lane_one = 1'b0;
    end
    // lane one idles with a toggling level, so nothing can lean on it
    always @(posedge clock) lane_one <= ~lane_one;
    // one frame: n bits out, m clocks in (two bits per clock when dual), sample on rise
    task automatic txn(input int n, input logic [39:0] v, input int m,
                       output logic [15:0] r);
        r = '0;
        @(posedge clock) cs_n <= 1'b0;
        for (int i = n + m - 1; i >= 0; i--) begin
            @(posedge clock);
            sclk <= 1'b0;
            mosi <= (i >= m) ? v[i - m] : ~mosi;
            repeat (5) @(posedge clock);
            sclk <= 1'b1;
            r = dual ? {r[13:0], miso, miso0} : {r[14:0], miso};
            repeat (2) @(posedge clock);
        end
        // cs rises right after the last bit, at the byte boundary
        repeat (3) @(posedge clock);
        sclk <= 1'b0;
        cs_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask : txn
endmodule : sfr_host

// [bench/sfr_core_tb.sv]
// sfr_core_tb: reads, unlock and erases through the host model.
// assumes the design side-loads bytes; erase times shortened.
`timescale 1ns/10ps
module sfr_core_tb
    import sfr_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, sclk, mosi, l1, lz, lzo, lo, loo, busy, wl, miso;
    logic [4:0] prot;
    logic load_we = 1'b0;
    logic [17:0] load_addr = '0;
    logic [7:0] load_data = '0, d0, d1;
    logic [15:0] got, q[$];
    logic rdy = 1'b0;
    logic dual = 1'b0;
    logic dls = 1'b0;
    logic miso0;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 41277;
    always #10 clock = ~clock;
    // lane one released: pulled high
    assign miso = loo ? lo : 1'b1;
    assign miso0 = lzo ? lz : 1'b1;
    sfr_host host (.clock(clock), .miso(miso), .cs_n(cs_n), .sclk(sclk),
        .mosi(mosi), .lane_one(l1), .miso0(miso0), .dual(dual));
    sfr_core #(.ADDR_W(18), .PAGE_CYC(2000), .FOUR_KB_CYC(2000),
        .SMALL_CYC(2000), .LARGE_CYC(2000)) dut (.clock(clock), .rst_n(rst_n),
        .cs_n_pin(cs_n), .sclk_pin(sclk), .io_lane_zero_in(mosi),
        .io_lane_zero_out(lz), .io_lane_zero_oe(lzo), .io_lane_one_in(l1),
        .io_lane_one_out(lo), .io_lane_one_oe(loo), .protect_level_bits(prot),
        .dummy_len_sel(dls), .load_we(load_we), .load_addr(load_addr),
        .load_data(load_data), .busy_flag(busy), .write_latch(wl));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    // read frame: note the expectation, then hand the result over
    task automatic rd(input int n, input logic [39:0] v, input int m,
                      input logic [15:0] e);
        logic [15:0] r;
        q.push_back(e);
        host.txn(n, v, m, r);
        got <= (m == 8 && !dual) ? {8'h00, r[7:0]} : r;
        rdy <= 1'b1;
        @(posedge clock) rdy <= 1'b0;
    endtask : rd
    // oldest note against each finished read
    always @(posedge clock) begin
        if (rdy) begin
            check(got, q.pop_front());
        end
    end
    // hang guard, far above the expected run length
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        logic [15:0] r;
        d0 = {1'b0, 7'($random(seed))};
        d1 = {1'b0, 7'($random(seed))};
        prot = 5'($random(seed));
        dls <= 1'($random(seed));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        // bytes at the top and at zero, so a read crosses the wrap
        load_we <= 1'b1;
        load_addr <= 18'h3FFFF;
        load_data <= d0;
        @(posedge clock);
        load_addr <= 18'h00000;
        load_data <= d1;
        @(posedge clock);
        load_we <= 1'b0;
        rd(32, {OP_READ, 24'h03FFFF}, 16, {d0, d1});
        rd(40, {OP_FAST_READ, 24'h03FFFF, 8'h00}, 8, {8'h00, d0});
        // two-lane data: eight clocks carry both bytes, upper bit on lane one
        dual <= 1'b1;
        rd(40, {OP_DUAL_OUT_READ, 24'h03FFFF, 8'h00}, 8, {d0, d1});
        dual <= 1'b0;
        host.txn(8, OP_WRITE_UNLOCK, 0, r);
        rd(8, OP_STATUS_READ, 8, {9'h000, prot, 2'b10});
        host.txn(32, {OP_PAGE_WIPE, 24'h000000}, 0, r);
        rd(8, OP_STATUS_READ, 8, {9'h000, prot, 2'b11});
        rd(40, {OP_FAST_READ, 24'h03FFFF, 8'h00}, 8, 16'h00FF);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clock);
        rd(8, OP_STATUS_READ, 8, {9'h000, prot, 2'b00});
        host.txn(32, {OP_PAGE_WIPE, 24'h03FF00}, 0, r);
        host.txn(8, OP_WRITE_UNLOCK, 0, r);
        host.txn(40, {OP_FOUR_KB_WIPE, 24'h03F000, 8'h00}, 0, r);
        rd(8, OP_STATUS_READ, 8, {9'h000, prot, 2'b10});
        rd(32, {OP_READ, 24'h03FFFF}, 16, {d0, ERASED_BYTE});
        repeat (4) @(posedge clock);
        test_done();
    end
endmodule : sfr_core_tb
